// ===== spc_asserts.sv
// checker for the apb handshake and pin ownership of the serial port
`timescale 1ns/1ps
`default_nettype none
module spc_asserts (
    input wire MCLK,
    input wire RST_B,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire SS_B_I,
    input wire SCK_O,
    input wire SCK_OE,
    input wire MOSI_O,
    input wire MOSI_OE,
    input wire MISO_OE,
    input wire SS_GPIO,
    input wire PIN_OWN,
    input wire PULLUP_EN,
    input wire RX_IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////////
    // apb: one wait state, one-cycle answer, refused reads give zero
    property p_rdy; PSEL && $rose(PENABLE) |=> PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_pls; PREADY |=> !PREADY; endproperty
    a_pls: assert property (p_pls) else $error("ready held");
    property p_err; PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("refused read not zero");
    // pins: ownership lags the enable by one register at most
    property p_own; MISO_OE || MOSI_OE || SCK_OE |-> PIN_OWN || $past(PIN_OWN);
    endproperty
    a_own: assert property (p_own)
        else $error("pin driven while off");
    property p_sel; SS_B_I [*6] |-> !MISO_OE; endproperty
    a_sel: assert property (p_sel)
        else $error("data out driven while deselected");
    property p_gpio; !PIN_OWN && !$past(PIN_OWN) |-> SS_GPIO; endproperty
    a_gpio: assert property (p_gpio)
        else $error("select not free while off");
    // open-drain lines only ever pull low
    property p_wom; !PULLUP_EN && !$past(PULLUP_EN) && MOSI_OE |-> !MOSI_O;
    endproperty
    a_wom: assert property (p_wom)
        else $error("wired-or line driven high");
    property p_rxi; RX_IRQ |-> PIN_OWN || $past(PIN_OWN); endproperty
    a_rxi: assert property (p_rxi)
        else $error("receive request while off");
    // smallest divisor still leaves two cycles per clock level
    property p_half; SCK_OE && $past(SCK_OE) && $changed(SCK_O)
        |=> !SCK_OE || $stable(SCK_O); endproperty
    a_half: assert property (p_half)
        else $error("serial clock level too short");
endmodule
`default_nettype wire

// ===== spc_clkgen.v
// master serial clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.vh"
module spc_clkgen (
    input wire clk,
    input wire rst_b,
    input wire run,
    input wire [1:0] rate,
    output reg tick
);
    reg [7:0] cnt_q;

    // divisor code to half-period length in bus cycles
    function [7:0] div_of;
        input [1:0] code;
        begin
            case (code)
                2'b00: div_of = `SPC_BD_0;
                2'b01: div_of = `SPC_BD_1;
                2'b10: div_of = `SPC_BD_2;
                default: div_of = `SPC_BD_3;
            endcase
        end
    endfunction

    // serial clock = bus clock / (2 * divisor)
    always @(posedge clk) begin
        if (!rst_b || !run) begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end else if (cnt_q == div_of(rate) - 8'd1) begin
            cnt_q <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'd1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== spc_consts.vh
// register map, field positions, reset values and timing counts
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_OFF_CTRL 4'h0
`define SPC_OFF_STAT 4'h4
`define SPC_OFF_DATA 4'h8
`define SPC_CTRL_RST 8'h28
`define SPC_B_RXIE 7
`define SPC_B_ROLE 5
`define SPC_B_CLOCK_IDLE_LEVEL 4
`define SPC_B_CLOCK_SAMPLE_PHASE 3
`define SPC_B_WOM 2
`define SPC_B_EN 1
`define SPC_B_TXIE 0
`define SPC_S_RXF 7
`define SPC_S_OVR 5
`define SPC_S_FLT 4
`define SPC_S_TXE 3
`define SPC_S_FEN 2
`define SPC_BD_0 8'd2
`define SPC_BD_1 8'd8
`define SPC_BD_2 8'd32
`define SPC_BD_3 8'd128
`define SPC_EDGES 4'd15
`endif

// ===== spc_peer.sv
// remote slave model hanging on the master-side pins
`timescale 1ns/1ps
`default_nettype none
module spc_peer (
    input wire sck,
    input wire mosi,
    input wire ss_b,
    input wire clock_idle_level,
    input wire clock_sample_phase,
    input wire [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [3:0] cnt = 4'h0;
    // a fresh frame starts at every deselect
    always @(posedge ss_b) begin
        cnt = 4'h0;
    end
    // reacts at the clock edge itself, like a real slave would
    always @(sck) begin
        if (!ss_b && cnt < 4'h8 && ((sck != clock_idle_level) ^ clock_sample_phase)) begin
            rx = {rx[6:0], mosi};
            cnt = cnt + 4'h1;
        end
    end
    // freed line shows the inverse of the last bit, never a stale copy
    assign miso = ss_b ? ~tx[0] : tx[~cnt[2:0]];
endmodule
`default_nettype wire

// ===== spc_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
    parameter W = 4
) (
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta_q;

    // first stage feeds only the second stage
    always @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== spc_top.v
// serial peripheral port: apb registers, shifter and pin control
//
// What this block does
// RULE_01 - slave drives its data-out only when selected; select high floats it
// RULE_02 - enabled port owns direction of data and clock pins
// RULE_03 - clock pin is output as master, input as slave; eight clocks a byte
// RULE_04 - master receives and transmits at the same time every transfer
// RULE_05 - far side toggles select between bytes in phase 0 only
// RULE_06 - slave select is always an input; fault enable only masks the flag
// RULE_07 - slave with select high ignores every serial clock edge
// RULE_08 - master select affects fault flag only with fault enable set
// RULE_09 - select use follows enable, role and fault enable table
// RULE_10 - wired-or bit disables pull-ups, pins become open-drain
// RULE_11 - receive interrupt enable gates receive-full request; reset clears it
// RULE_12 - receive-full sets whenever a completed byte reaches receive buffer
// RULE_13 - role bit: 1 master, 0 slave; reset selects master
// RULE_14 - polarity bit sets idle clock level; reset clears it
// RULE_15 - phase bit sets data timing; reset sets it; both ends must match
// RULE_16 - phase 0 slave starts on select fall, driving msb out
// RULE_17 - phase 0 slave takes no new shift data once started
// RULE_18 - phase 1 slave starts on the first serial clock edge
// RULE_19 - select high leaves the transfer state untouched
// RULE_20 - enable bit activates; clearing it partially resets; reset clears it
// RULE_21 - transmit interrupt enable gates transmit-empty request
// RULE_22 - while disabled: tx empty set, transfer aborted, shifter cleared
// RULE_23 - fault flag: slave select rise mid-transfer, master select low
// RULE_24 - master rate bits pick divisor 2, 8, 32 or 128
// RULE_25 - polarity 0 idles low, 1 idles high; msb first both ways
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.vh"
module spc_top (
    input wire MCLK,
    input wire RST_B,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [3:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire SCK_I,
    output reg SCK_O,
    output reg SCK_OE,
    input wire MOSI_I,
    output reg MOSI_O,
    output reg MOSI_OE,
    input wire MISO_I,
    output reg MISO_O,
    output reg MISO_OE,
    input wire SS_B_I,
    output reg SS_GPIO,
    output reg PIN_OWN,
    output reg PULLUP_EN,
    output reg RX_IRQ,
    output reg TX_IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // registers and pin samples
    reg [7:0] ctrl_q;
    reg [2:0] fen_rate_q;
    reg rx_full_q, ovr_q, fault_q, tx_empty_q, fault_arm_q;
    reg [7:0] tx_buf_q, rx_buf_q, sh_q;
    reg [3:0] cnt_q;
    reg busy_q, out_q, phase_q, sck_prev_q, ss_prev_q;
    wire [3:0] pins;
    wire tick;

    wire en = ctrl_q[`SPC_B_EN];
    wire master = ctrl_q[`SPC_B_ROLE];
    wire clock_idle_level = ctrl_q[`SPC_B_CLOCK_IDLE_LEVEL];
    wire clock_sample_phase = ctrl_q[`SPC_B_CLOCK_SAMPLE_PHASE];
    wire wom = ctrl_q[`SPC_B_WOM];
    wire fen = fen_rate_q[2];
    wire sck_s = pins[3];
    wire mosi_s = pins[2];
    wire miso_s = pins[1];
    wire ss_b_s = pins[0];

    // every pin input passes two flops before any logic sees it
    spc_sync #(.W(4)) u_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .din({SCK_I, MOSI_I, MISO_I, SS_B_I}),
        .dout(pins)
    );

    // divider runs only during a master transfer
    spc_clkgen u_clkgen (
        .clk(MCLK),
        .rst_b(RST_B),
        .run(en & master & busy_q),
        .rate(fen_rate_q[1:0]),
        .tick(tick)
    ); // [RULE_24]

    ////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, writes land on the completing edge
    wire acc = PSEL & PENABLE & PREADY;
    wire wr = acc & PWRITE;
    wire rd = acc & ~PWRITE;
    wire a_ctrl = PADDR == `SPC_OFF_CTRL;
    wire a_stat = PADDR == `SPC_OFF_STAT;
    wire a_data = PADDR == `SPC_OFF_DATA;
    wire a_ok = a_ctrl | a_stat | a_data;
    wire [7:0] stat_v = {rx_full_q, 1'b0, ovr_q, fault_q, tx_empty_q,
        fen_rate_q};

    // ready pulses for one cycle; read data captured with it
    always @(posedge MCLK) begin
        if (!RST_B) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~a_ok;
            if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
                if (a_ctrl)
                    PRDATA <= {24'h000000, ctrl_q};
                else if (a_stat)
                    PRDATA <= {24'h000000, stat_v};
                else if (a_data)
                    PRDATA <= {24'h000000, rx_buf_q};
                else
                    PRDATA <= 32'h00000000;
            end else begin
                PRDATA <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine events
    wire slave_on = en & ~master;
    wire sel = slave_on & ~ss_b_s;
    // select high masks clocks but never touches the counter or shifter
    wire s_edge = sel & (sck_s != sck_prev_q); // [RULE_07] [RULE_19]
    wire ss_fall = slave_on & ss_prev_q & ~ss_b_s;
    wire ss_rise = slave_on & ~ss_prev_q & ss_b_s;
    wire m_edge = en & master & busy_q & tick;
    wire edge_ev = busy_q & (m_edge | s_edge);
    wire lead = ~cnt_q[0];
    wire samp = lead ^ clock_sample_phase; // [RULE_15]
    wire din = master ? miso_s : mosi_s; // [RULE_04]
    wire [7:0] sh_in = {sh_q[6:0], din}; // [RULE_25]
    wire last = cnt_q == `SPC_EDGES;
    wire [7:0] rx_next = samp ? sh_in : sh_q;
    wire s_start1 = ~busy_q & clock_sample_phase & s_edge; // [RULE_18]
    wire s_start0 = ~busy_q & ~clock_sample_phase & ss_fall; // [RULE_16]
    wire done = edge_ev & last;
    wire idle_load = en & ~busy_q & ~tx_empty_q & ~s_start1;
    wire master_flt = en & master & fen & ~ss_b_s; // [RULE_08] [RULE_23]
    wire slave_flt = slave_on & fen & busy_q & ss_rise; // [RULE_06] [RULE_23]

    // shifter, counter and transfer state
    always @(posedge MCLK) begin
        if (!RST_B || !en) begin
            sh_q <= 8'h00; // [RULE_22]
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            out_q <= 1'b0;
            phase_q <= 1'b0;
        end else if (idle_load) begin
            // buffer empties into the shifter only while idle
            sh_q <= tx_buf_q; // [RULE_17] [RULE_21]
            out_q <= tx_buf_q[7];
            cnt_q <= 4'h0;
            busy_q <= master;
            phase_q <= 1'b0;
        end else if (s_start0) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
            out_q <= sh_q[7]; // [RULE_16]
        end else if (s_start1) begin
            // first edge is a drive edge in phase 1
            busy_q <= 1'b1;
            cnt_q <= 4'h1;
            out_q <= sh_q[7]; // [RULE_18]
        end else if (edge_ev) begin
            phase_q <= master ? ~phase_q : phase_q;
            cnt_q <= cnt_q + 4'h1;
            if (samp)
                sh_q <= sh_in;
            else
                out_q <= sh_q[7];
            if (last) begin
                busy_q <= 1'b0; // [RULE_03]
                phase_q <= 1'b0;
                sh_q <= rx_next;
            end
        end
    end

    // edge and select history for the slave
    always @(posedge MCLK) begin
        if (!RST_B) begin
            sck_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            ss_prev_q <= ss_b_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and status registers; hardware set wins over software clear
    always @(posedge MCLK) begin
        if (!RST_B) begin
            ctrl_q <= `SPC_CTRL_RST; // [RULE_13] [RULE_14] [RULE_15] [RULE_20]
            fen_rate_q <= 3'h0;
            tx_buf_q <= 8'h00;
            rx_buf_q <= 8'h00;
            rx_full_q <= 1'b0;
            ovr_q <= 1'b0;
            fault_q <= 1'b0;
            fault_arm_q <= 1'b0;
            tx_empty_q <= 1'b1;
        end else begin
            if (wr & a_ctrl)
                ctrl_q <= PWDATA[7:0];
            if (wr & a_stat)
                fen_rate_q <= PWDATA[2:0];
            // master fault drops the enable as a partial reset
            if (master_flt)
                ctrl_q[`SPC_B_EN] <= 1'b0; // [RULE_20]
            // transmit buffer
            if (wr & a_data) begin
                tx_buf_q <= PWDATA[7:0];
                tx_empty_q <= 1'b0;
            end
            if (!en || idle_load)
                tx_empty_q <= 1'b1; // [RULE_22] [RULE_21]
            // receive buffer: data read clears full and overflow
            if (rd & a_data) begin
                rx_full_q <= 1'b0;
                ovr_q <= 1'b0;
            end
            if (done) begin
                if (rx_full_q)
                    ovr_q <= 1'b1; // old byte kept, new one lost
                else
                    rx_buf_q <= rx_next;
                rx_full_q <= 1'b1; // [RULE_12]
            end
            // fault clears by status read with flag set, then ctrl write
            if (rd & a_stat & fault_q)
                fault_arm_q <= 1'b1;
            if (wr & a_ctrl & fault_arm_q) begin
                fault_q <= 1'b0;
                fault_arm_q <= 1'b0;
            end
            if (master_flt | slave_flt)
                fault_q <= 1'b1; // [RULE_23]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, all registered

    // open-drain drives only lows; push-pull drives both levels
    function [1:0] drive;
        input own;
        input val;
        input od;
        begin
            drive[1] = own & ~(od & val); // enable
            drive[0] = od ? 1'b0 : val;
        end
    endfunction

    wire m_own = en & master;
    wire [1:0] sck_d = drive(m_own, phase_q ^ clock_idle_level, wom); // [RULE_03]
    wire [1:0] mosi_d = drive(m_own, out_q, wom); // [RULE_04]
    wire [1:0] miso_d = drive(sel, out_q, wom); // [RULE_01]

    // pin ownership and interrupt requests
    always @(posedge MCLK) begin
        if (!RST_B) begin
            SCK_O <= 1'b0;
            SCK_OE <= 1'b0;
            MOSI_O <= 1'b0;
            MOSI_OE <= 1'b0;
            MISO_O <= 1'b0;
            MISO_OE <= 1'b0;
            SS_GPIO <= 1'b1;
            PIN_OWN <= 1'b0;
            PULLUP_EN <= 1'b1;
            RX_IRQ <= 1'b0;
            TX_IRQ <= 1'b0;
        end else begin
            SCK_OE <= sck_d[1]; // [RULE_02] [RULE_14] [RULE_25]
            SCK_O <= sck_d[0];
            MOSI_OE <= mosi_d[1];
            MOSI_O <= mosi_d[0];
            MISO_OE <= miso_d[1]; // [RULE_01] [RULE_02]
            MISO_O <= miso_d[0];
            SS_GPIO <= ~en | (master & ~fen); // [RULE_09] [RULE_06]
            PIN_OWN <= en; // [RULE_02] [RULE_22]
            PULLUP_EN <= ~wom; // [RULE_10]
            RX_IRQ <= en & ctrl_q[`SPC_B_RXIE] & rx_full_q; // [RULE_11]
            TX_IRQ <= ctrl_q[`SPC_B_TXIE] & tx_empty_q; // [RULE_21]
        end
    end
endmodule
`default_nettype wire

// ===== spi_pins_and_control_bench.sv
// testbench: apb master, slave model on the pins, queued read checks
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.vh"
module spi_pins_and_control_bench;
    localparam logic [3:0] CT = `SPC_OFF_CTRL, ST = `SPC_OFF_STAT;
    localparam logic [3:0] DT = `SPC_OFF_DATA;
    localparam logic [7:0] M = 8'h1 << `SPC_B_ROLE, E = 8'h1 << `SPC_B_EN;
    localparam logic [7:0] PL = 8'h1 << `SPC_B_CLOCK_IDLE_LEVEL, PH = 8'h1 << `SPC_B_CLOCK_SAMPLE_PHASE;
    localparam logic [7:0] IE = 8'h1 << `SPC_B_RXIE | 8'h1 << `SPC_B_TXIE;
    localparam logic [7:0] WOM = 8'h1 << `SPC_B_WOM, TXE = 8'h1 << `SPC_S_TXE;
    localparam logic [7:0] FEN = 8'h1 << `SPC_S_FEN, FLT = 8'h1 << `SPC_S_FLT;
    logic MCLK = 1'h0, RST_B = 1'h0, PSEL = 1'h0, PENABLE = 1'h0;
    logic PWRITE = 1'h0, s_sck = 1'h0, s_mosi = 1'h0, s_ss = 1'h1;
    logic p_ss = 1'h1, p_clock_idle_level = 1'h0, p_clock_sample_phase = 1'h0;
    logic [3:0] PADDR = 4'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE;
    logic SS_GPIO, PIN_OWN, PULLUP_EN, RX_IRQ, TX_IRQ, p_miso;
    logic [7:0] p_tx = 8'h0, p_rx, d, r, g;
    logic [32:0] q[$];
    integer n_fail = 0, checks_done = 0, i, n;
    // pin levels: whoever drives wins, the bench stands in otherwise
    wire sck_w = SCK_OE ? SCK_O : s_sck;
    wire mosi_w = MOSI_OE ? MOSI_O : s_mosi;
    wire miso_w = MISO_OE ? MISO_O : p_miso;
    spc_top dut_u (
        .MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .SCK_I(sck_w), .SCK_O, .SCK_OE, .MOSI_I(mosi_w),
        .MOSI_O, .MOSI_OE, .MISO_I(miso_w), .MISO_O, .MISO_OE,
        .SS_B_I(s_ss), .SS_GPIO, .PIN_OWN, .PULLUP_EN, .RX_IRQ, .TX_IRQ
    );
    spc_peer peer_u (
        .sck(sck_w), .mosi(mosi_w), .ss_b(p_ss), .clock_idle_level(p_clock_idle_level),
        .clock_sample_phase(p_clock_sample_phase), .tx(p_tx), .miso(p_miso), .rx(p_rx)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        test_done;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input integer c);
        repeat (c) @(posedge MCLK);
    endtask
    // apb cycle: request held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [3:0] a,
                       input logic [7:0] wd, input logic [32:0] e);
        integer k;
        @(posedge MCLK);
        if (!w) q.push_back(e);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h0, wd};
        @(posedge MCLK);
        PENABLE <= 1'h1;
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while (PREADY !== 1'h1 && k < 50);
        if (k >= 50) tmo;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [32:0] e);
        apb(1'h0, a, 8'h0, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        apb(1'h1, a, v, 33'h0);
    endtask
    // bench as remote master on the slave-side pins, clock idles low
    task automatic sbyte(input logic ph, input logic [7:0] t,
                         output logic [7:0] o);
        integer b;
        for (b = 7; b >= 0; b--) begin
            if (!ph) s_mosi <= t[b];
            wt(6);
            if (!ph) o[b] = miso_w;
            s_sck <= 1'h1;
            if (ph) s_mosi <= t[b];
            wt(6);
            if (ph) o[b] = miso_w;
            s_sck <= 1'h0;
        end
    endtask
    // read answers are matched against the oldest note
    always @(posedge MCLK) begin
        if (PREADY === 1'h1 && PWRITE === 1'h0 && q.size() > 0)
            chk({PSLVERR, PRDATA}, q.pop_front());
    end
    initial begin
        forever #2 MCLK = ~MCLK;
    end
    initial begin
        void'($urandom(4));
        wt(4);
        RST_B <= 1'h1;
        rd(CT, {25'h0, `SPC_CTRL_RST});
        rd(ST, {25'h0, TXE});
        rd(4'hC, {1'h1, 32'h0});
        // master: every mode and every rate code, one byte each
        for (i = 0; i < 4; i++) begin
            p_clock_idle_level = i[1];
            p_clock_sample_phase = i[0];
            d = $urandom;
            p_tx = $urandom;
            wr(ST, {6'h0, i[1:0]});
            wr(CT, M | E | IE | (i[1] ? PL : 8'h0) | (i[0] ? PH : 8'h0));
            p_ss = 1'h0;
            wr(DT, d);
            n = 0;
            while (RX_IRQ !== 1'h1 && n < 9000) begin
                wt(1);
                n++;
            end
            if (n >= 9000) tmo;
            chk(p_rx, d);
            chk({SCK_O, TX_IRQ}, {p_clock_idle_level, 1'h1});
            p_ss = 1'h1;
            rd(DT, {25'h0, p_tx});
            wt(3);
            chk(RX_IRQ, 1'h0);
        end
        // disable in mid-byte aborts and empties the transmitter
        wr(DT, 8'h5A);
        wt(700);
        wr(CT, M | IE);
        wt(2);
        chk({PIN_OWN, SS_GPIO, SCK_OE, MOSI_OE, TX_IRQ}, 5'h09);
        rd(ST, {25'h0, TXE | 8'h3});
        // select as free pin, then as fault input of a master
        wr(CT, M | E);
        s_ss <= 1'h0;
        wt(6);
        chk(SS_GPIO, 1'h1);
        rd(ST, {25'h0, TXE | 8'h3});
        wr(ST, FEN);
        wt(6);
        rd(ST, {25'h0, FLT | FEN | TXE});
        chk(PIN_OWN, 1'h0);
        s_ss <= 1'h1;
        wt(4);
        wr(CT, M | E | WOM);
        wt(4);
        chk({SS_GPIO, PULLUP_EN, PIN_OWN}, 3'h1);
        wr(ST, 8'h0);
        // slave in both phases, then clocks while deselected
        for (i = 0; i < 2; i++) begin
            d = $urandom;
            r = $urandom;
            wr(CT, E | (i[0] ? PH : 8'h0));
            wr(DT, d);
            s_ss <= 1'h0;
            sbyte(i[0], r, g);
            wt(8);
            chk(g, d);
            chk(SS_GPIO, 1'h0);
            s_ss <= 1'h1;
            rd(DT, {25'h0, r});
            wt(6);
            chk(MISO_OE, 1'h0);
        end
        sbyte(1'h1, 8'hFF, g);
        wt(8);
        rd(ST, {25'h0, TXE});
        wt(4);
        test_done;
    end
endmodule
bind spc_top spc_asserts chk_u (
    .MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PRDATA, .PREADY, .PSLVERR,
    .SS_B_I, .SCK_O, .SCK_OE, .MOSI_O, .MOSI_OE, .MISO_OE, .SS_GPIO,
    .PIN_OWN, .PULLUP_EN, .RX_IRQ
);
`default_nettype wire
